// ===== src/spc_regs.svh
// What this block does
// - enabled module drives the shared transmit pin as output while the transmitter is enabled or busy, ignoring port direction
// - enabled module treats the shared receive pin as input, ignoring port direction
// - module enable low hands both pins back to general-purpose port control
// - transmitter disabled: transmit pin floats once the running frame ends
// - transmitter enabled: plain or infrared-encoded output, idling high
// - receive pin sampled only while receiver enabled; line idles high or is terminated
// - loop mode feeds transmitter into receiver, pin and infrared coder bypassed
// - module enable runs baud generator; clearing it sets empty and complete flags
// - length bit picks 9-bit (1) or 8-bit (0) characters
// - one start, one stop bit; 10 or 11 bit frames, parity takes data bit
// - parity bit sits in the character's most significant bit, sent and checked
// - parity type 1 is odd, 0 is even
// - wake bit 1 wakes on address mark, 0 on idle line
// - idle type 1 counts ones after stop bit, 0 after start bit
// - empty and complete flags each request transmit interrupt when enabled
// - receive full and idle flags each request receive interrupt when enabled
// - transmitter enable rising sends a preamble of 10 or 11 ones
// - transmitter disable finishes the frame in progress, then the transmit pin is released and floats
// - disable then enable during a frame queues one idle character afterwards
// - receiver disable stops receiving but keeps receive flags
// - reset clears every bit of both control registers
// - break bit sends break characters, then one more bit once cleared, a mark with 9-bit characters and low with 8-bit
// - standby bit silences receive interrupts; wakeup condition and reset clear it
/*
 * register map, field positions, reset values and timing counts.
 * assumes word-aligned byte addresses on a 32-bit avalon-mm slave.
 */
`ifndef SPC_REGS_SVH
`define SPC_REGS_SVH

`define SPC_IDX_CTRL1      3'h0
`define SPC_IDX_CTRL2      3'h1
`define SPC_IDX_STATUS     3'h2
`define SPC_IDX_DATA       3'h3
`define SPC_IDX_BAUD       3'h4
`define SPC_IDX_IRCTL      3'h5

`define SPC_CTRL1_RESET    8'h00
`define SPC_CTRL2_RESET    8'h00
`define SPC_BAUD_RESET     8'h00
`define SPC_STATUS_W1C     8'h1b

`define SPC_OVERSAMPLE     4'hf
`define SPC_MID_START      4'h7
`define SPC_IR_PULSE       4'h3
`define SPC_BITS_8         4'ha
`define SPC_BITS_9         4'hb

`endif

// ===== src/spc_pkg.sv
/*
 * types shared by the serial port control block.
 * assumes nothing beyond the register header.
 */
package spc_pkg;

    typedef struct packed {
        logic loopback_select;
        logic module_enable_bit;
        logic rsvd;
        logic long_char;
        logic wake_on_mark;
        logic idle_count_type;
        logic parity_enable;
        logic parity_type;
    } spc_ctrl1_t;

    typedef struct packed {
        logic tx_empty_irq_enable;
        logic tx_complete_irq_enable;
        logic rx_full_irq_enable;
        logic idle_irq_enable;
        logic transmitter_enable;
        logic receiver_enable;
        logic receiver_standby_bit;
        logic send_break_bit;
    } spc_ctrl2_t;

    typedef struct packed {
        logic tx_empty_flag;
        logic tx_complete_flag;
        logic rx_full_flag;
        logic idle_flag;
        logic overrun_flag;
        logic noise_flag;
        logic framing_flag;
        logic parity_flag;
    } spc_status_t;

    typedef enum logic [2:0] {
        TX_IDLE,
        TX_PRE,
        TX_BRK,
        TX_MARK,
        TX_DATA
    } spc_tx_state_t;

    typedef enum logic [1:0] {
        RX_IDLE,
        RX_START,
        RX_DATA
    } spc_rx_state_t;

endpackage : spc_pkg

// ===== src/spc_top.sv
/*
 * serial port with infrared option: avalon-mm register slave, transmitter,
 * receiver, pin sharing with the general-purpose port.
 * assumes a synchronous receive pin and an outside pad resolving the enables.
 */
`timescale 1ns/10ps
`include "spc_regs.svh"

module spc_top
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // avalon-mm slave
    input  wire logic [4:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    // general-purpose port side of the shared pins
    input  wire logic        port_dir_bit_zero,
    input  wire logic        port_dir_bit_one,
    input  wire logic        port_out_zero,
    input  wire logic        port_out_one,
    // shared pins
    output logic             shared_transmit_pin_out,
    output logic             shared_transmit_pin_oe,
    input  wire logic        shared_receive_pin_in,
    output logic             shared_receive_pin_out,
    output logic             shared_receive_pin_oe,
    // interrupt request lines
    output logic             tx_irq,
    output logic             rx_irq
);

    function automatic logic par_bit(input logic [8:0] ch,
                                     input logic       long_char,
                                     input logic       odd);
        par_bit = (long_char ? ^ch[7:0] : ^ch[6:0]) ^ odd;
    endfunction : par_bit

    spc_pkg::spc_ctrl1_t    ctrl1;
    spc_pkg::spc_ctrl2_t    ctrl2;
    spc_pkg::spc_status_t   stat;
    logic [7:0]             baud_div;
    logic                   infrared_enable;
    logic [8:0]             tx_hold;
    logic [8:0]             rx_data;
    logic                   ack;
    logic [7:0]             div_cnt;
    spc_pkg::spc_tx_state_t tx_state;
    logic [10:0]            tx_shift;
    logic [3:0]             tx_bits;
    logic [3:0]             tx_phase;
    logic                   te_q;
    logic                   pend_pre;
    spc_pkg::spc_rx_state_t rx_state;
    logic [9:0]             rx_shift;
    logic [3:0]             rx_bits;
    logic [3:0]             rx_phase;
    logic [3:0]             ones_cnt;
    logic                   idle_armed;
    logic [3:0]             ir_hold;
    logic                   rx_wake;

    // bus decode
    wire         req      = read | write;
    wire         acc      = req & ack;
    wire [2:0]   idx      = address[4:2];
    wire         wr       = write & acc;
    wire         wr_c1    = wr & (idx == `SPC_IDX_CTRL1);
    wire         wr_c2    = wr & (idx == `SPC_IDX_CTRL2);
    wire         wr_st    = wr & (idx == `SPC_IDX_STATUS);
    wire         wr_dat   = wr & (idx == `SPC_IDX_DATA);
    wire         wr_baud  = wr & (idx == `SPC_IDX_BAUD);
    wire         wr_ir    = wr & (idx == `SPC_IDX_IRCTL);
    wire         rd_dat   = read & acc & (idx == `SPC_IDX_DATA);
    wire [7:0]   w1c      = writedata[7:0] & `SPC_STATUS_W1C;

    wire         en       = ctrl1.module_enable_bit;
    wire         te       = ctrl2.transmitter_enable;
    wire         re       = ctrl2.receiver_enable;
    wire         loop_on  = ctrl1.loopback_select & te & re;
    wire [3:0]   nbits    = ctrl1.long_char ? `SPC_BITS_9 : `SPC_BITS_8;
    wire         tick     = en & (div_cnt == baud_div);
    wire         tx_busy  = tx_state != spc_pkg::TX_IDLE;

    // read mux
    logic [31:0] rd_mux;
    always_comb
    begin
        case (idx)
            `SPC_IDX_CTRL1:  rd_mux = {24'h0, ctrl1};
            `SPC_IDX_CTRL2:  rd_mux = {24'h0, ctrl2};
            `SPC_IDX_STATUS: rd_mux = {24'h0, stat};
            `SPC_IDX_DATA:   rd_mux = {23'h0, rx_data};
            `SPC_IDX_BAUD:   rd_mux = {24'h0, baud_div};
            `SPC_IDX_IRCTL:  rd_mux = {31'h0, infrared_enable};
            default:         rd_mux = 32'h0;
        endcase
    end

    // one wait state: request seen at edge 1, taken at edge 2
    assign waitrequest = req & ~ack;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ack      <= 1'b0;
            readdata <= 32'h0;
        end
        else
        begin
            ack <= req & ~ack;
            if (req & ~ack)
                readdata <= rd_mux;
        end
    end

    // control registers
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl1           <= `SPC_CTRL1_RESET;
            ctrl2           <= `SPC_CTRL2_RESET;
            baud_div        <= `SPC_BAUD_RESET;
            infrared_enable <= 1'b0;
            tx_hold         <= 9'h0;
        end
        else
        begin
            if (wr_c1)
            begin
                ctrl1      <= writedata[7:0];
                ctrl1.rsvd <= 1'b0;
            end
            if (wr_c2)
                ctrl2 <= writedata[7:0];
            else if (rx_wake)
                ctrl2.receiver_standby_bit <= 1'b0;
            if (wr_baud)
                baud_div <= writedata[7:0];
            if (wr_ir)
                infrared_enable <= writedata[0];
            if (wr_dat)
                tx_hold <= writedata[8:0];
        end
    end

    // baud divider: oversample tick, sixteen per bit
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            div_cnt <= 8'h0;
        else if (!en || tick)
            div_cnt <= 8'h0;
        else
            div_cnt <= div_cnt + 8'h1;
    end

    // transmitter
    wire       te_rise  = te & ~te_q;
    wire       tx_bit_end = tx_busy & tick & (tx_phase == `SPC_OVERSAMPLE);
    wire       tx_last  = tx_bit_end & (tx_bits == 4'h1);
    wire [8:0] tx_char  = ctrl1.parity_enable ?
        (ctrl1.long_char ?
            {par_bit(tx_hold, 1'b1, ctrl1.parity_type), tx_hold[7:0]} :
            {1'b1, par_bit(tx_hold, 1'b0, ctrl1.parity_type),
             tx_hold[6:0]}) :
        (ctrl1.long_char ? tx_hold : {1'b1, tx_hold[7:0]});
    wire       tx_load  = en & te & ~tx_busy & ~pend_pre & ~te_rise
                          & ~ctrl2.send_break_bit & ~stat.tx_empty_flag;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tx_state <= spc_pkg::TX_IDLE;
            tx_shift <= 11'h7ff;
            tx_bits  <= 4'h0;
            tx_phase <= 4'h0;
            te_q     <= 1'b0;
            pend_pre <= 1'b0;
        end
        else
        begin
            te_q <= te;
            if (!en)
            begin
                tx_state <= spc_pkg::TX_IDLE;
                tx_shift <= 11'h7ff;
                pend_pre <= 1'b0;
            end
            else if (!tx_busy)
            begin
                tx_phase <= 4'h0;
                tx_bits  <= nbits;
                if (te & (pend_pre | te_rise))
                begin
                    tx_state <= spc_pkg::TX_PRE;
                    tx_shift <= 11'h7ff;
                    pend_pre <= 1'b0;
                end
                else if (te & ctrl2.send_break_bit)
                begin
                    tx_state <= spc_pkg::TX_BRK;
                    tx_shift <= 11'h0;
                end
                else if (tx_load)
                begin
                    tx_state <= spc_pkg::TX_DATA;
                    tx_shift <= {1'b1, tx_char, 1'b0};
                end
            end
            else
            begin
                if (te_rise)
                    pend_pre <= 1'b1;
                if (tick)
                    tx_phase <= tx_phase + 4'h1;
                if (tx_bit_end)
                begin
                    tx_bits  <= tx_bits - 4'h1;
                    tx_shift <= {1'b1, tx_shift[10:1]};
                end
                if (tx_last)
                begin
                    // break repeats while held, then one more bit: mark with 9-bit characters, low with 8-bit
                    if (tx_state == spc_pkg::TX_BRK && ctrl2.send_break_bit)
                    begin
                        tx_bits  <= nbits;
                        tx_shift <= 11'h0;
                    end
                    else if (tx_state == spc_pkg::TX_BRK)
                    begin
                        tx_state <= spc_pkg::TX_MARK;
                        tx_bits  <= 4'h1;
                    end
                    else
                        tx_state <= spc_pkg::TX_IDLE;
                end
            end
        end
    end

    wire tx_line = tx_busy ? tx_shift[0] : 1'b1;
    // infrared: a zero bit is a short low pulse at the head of the bit
    wire ir_line = tx_line | (tx_phase >= `SPC_IR_PULSE);

    // pin ownership
    always_comb
    begin
        if (en)
        begin
            shared_transmit_pin_oe  = te | tx_busy;
            shared_transmit_pin_out = infrared_enable ? ir_line : tx_line;
            shared_receive_pin_oe   = 1'b0;
            shared_receive_pin_out  = 1'b0;
        end
        else
        begin
            shared_transmit_pin_oe  = port_dir_bit_zero;
            shared_transmit_pin_out = port_out_zero;
            shared_receive_pin_oe   = port_dir_bit_one;
            shared_receive_pin_out  = port_out_one;
        end
    end

    // receiver input select
    wire ir_rx  = shared_receive_pin_in & (ir_hold == 4'h0);
    wire pin_rx = infrared_enable ? ir_rx : shared_receive_pin_in;
    wire rx_in  = loop_on ? tx_line : pin_rx;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            ir_hold <= 4'h0;
        else if (!shared_receive_pin_in)
            ir_hold <= `SPC_OVERSAMPLE;
        else if (tick && ir_hold != 4'h0)
            ir_hold <= ir_hold - 4'h1;
    end

    // receiver
    wire       rx_run     = en & re;
    wire       rx_sample  = rx_run & tick & (rx_phase == `SPC_OVERSAMPLE);
    wire       rx_dsample = rx_sample & (rx_state == spc_pkg::RX_DATA);
    wire [9:0] next_rx_shift = {rx_in, rx_shift[9:1]};
    wire       rx_done    = rx_dsample & (rx_bits == nbits - 4'h2);
    wire [8:0] rx_char    = ctrl1.long_char ? next_rx_shift[8:0]
                                            : {1'b0, next_rx_shift[8:1]};
    wire       rx_msb     = ctrl1.long_char ? rx_char[8] : rx_char[7];
    wire       rx_par_bad = ctrl1.parity_enable &
        (par_bit(rx_char, ctrl1.long_char, ctrl1.parity_type) != rx_msb);
    wire       standby    = ctrl2.receiver_standby_bit;
    wire       mark_wake  = rx_done & standby & ctrl1.wake_on_mark & rx_msb;
    wire       rx_keep    = rx_done & (~standby | mark_wake);
    wire       idle_sample = rx_sample & rx_in & (ones_cnt < nbits);
    wire       idle_hit   = idle_sample & (ones_cnt == nbits - 4'h1);
    wire       idle_wake  = idle_hit & standby & ~ctrl1.wake_on_mark;
    assign rx_wake = mark_wake | idle_wake;
    wire       idle_set   = idle_hit & ~idle_wake & idle_armed;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rx_state <= spc_pkg::RX_IDLE;
            rx_shift <= 10'h0;
            rx_bits  <= 4'h0;
            rx_phase <= 4'h0;
            ones_cnt <= 4'h0;
        end
        else if (!rx_run)
        begin
            rx_state <= spc_pkg::RX_IDLE;
            rx_phase <= 4'h0;
            ones_cnt <= 4'h0;
        end
        else
        begin
            if (tick)
                rx_phase <= rx_phase + 4'h1;
            if (idle_sample)
                ones_cnt <= ones_cnt + 4'h1;
            case (rx_state)
                spc_pkg::RX_IDLE:
                    if (!rx_in)
                    begin
                        rx_state <= spc_pkg::RX_START;
                        rx_phase <= 4'h0;
                        ones_cnt <= 4'h0;
                    end
                spc_pkg::RX_START:
                    if (tick && rx_phase == `SPC_MID_START)
                    begin
                        rx_state <= rx_in ? spc_pkg::RX_IDLE
                                          : spc_pkg::RX_DATA;
                        rx_phase <= 4'h0;
                        rx_bits  <= 4'h0;
                    end
                spc_pkg::RX_DATA:
                    if (rx_sample)
                    begin
                        rx_shift <= next_rx_shift;
                        rx_bits  <= rx_bits + 4'h1;
                        // ones counted after start or only after stop
                        if (!rx_in || ctrl1.idle_count_type)
                            ones_cnt <= 4'h0;
                        if (rx_done)
                            rx_state <= spc_pkg::RX_IDLE;
                    end
                default:
                    rx_state <= spc_pkg::RX_IDLE;
            endcase
        end
    end

    // status flags: hardware set wins over software clear
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stat       <= 8'hc0;
            rx_data    <= 9'h0;
            idle_armed <= 1'b0;
        end
        else
        begin
            // the load frees the holding word, so it may be refilled at once
            if (!en || tx_load)
                stat.tx_empty_flag <= 1'b1;
            else if (wr_dat)
                stat.tx_empty_flag <= 1'b0;
            stat.tx_complete_flag <= !en | (stat.tx_empty_flag & ~tx_busy
                & ~pend_pre & ~(te & ctrl2.send_break_bit));
            if (rx_keep && !stat.rx_full_flag)
            begin
                stat.rx_full_flag <= 1'b1;
                rx_data           <= rx_char;
                stat.framing_flag <= ~next_rx_shift[9];
                stat.parity_flag  <= rx_par_bad;
                idle_armed        <= 1'b1;
            end
            else if (rd_dat)
                stat.rx_full_flag <= 1'b0;
            if (rx_keep && stat.rx_full_flag)
                stat.overrun_flag <= 1'b1;
            else if (wr_st && w1c[3])
                stat.overrun_flag <= 1'b0;
            if (idle_set)
            begin
                stat.idle_flag <= 1'b1;
                idle_armed     <= 1'b0;
            end
            else if (wr_st && w1c[4])
                stat.idle_flag <= 1'b0;
            if (wr_st && w1c[1] && !(rx_keep && !stat.rx_full_flag))
                stat.framing_flag <= 1'b0;
            if (wr_st && w1c[0] && !(rx_keep && !stat.rx_full_flag))
                stat.parity_flag <= 1'b0;
            stat.noise_flag <= 1'b0;
        end
    end

    // interrupt request lines
    assign tx_irq = en &
        ((ctrl2.tx_empty_irq_enable & stat.tx_empty_flag) |
         (ctrl2.tx_complete_irq_enable & stat.tx_complete_flag));
    assign rx_irq = ~standby &
        ((ctrl2.rx_full_irq_enable & stat.rx_full_flag) |
         (ctrl2.idle_irq_enable & stat.idle_flag));

endmodule : spc_top

// ===== verif/spc_chk.sv
/* port checker for spc_top.
   assumes one bus master and mirrors the control bits it writes. */
`timescale 1ns/10ps
module spc_chk
(
    // clock, reset, bus
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic [4:0]  address,
    input wire logic        read,
    input wire logic        write,
    input wire logic [31:0] writedata,
    input wire logic        waitrequest,
    // pins and irqs
    input wire logic        port_dir_bit_zero,
    input wire logic        port_dir_bit_one,
    input wire logic        port_out_zero,
    input wire logic        port_out_one,
    input wire logic        shared_transmit_pin_out,
    input wire logic        shared_transmit_pin_oe,
    input wire logic        shared_receive_pin_out,
    input wire logic        shared_receive_pin_oe,
    input wire logic        tx_irq,
    input wire logic        rx_irq
);
    logic en, te, ti, ri;
    wire  take = write && !waitrequest;
    // shadows follow the edge at which a write takes effect
    always_ff @(posedge clk or negedge rst_n)
        if (!rst_n)
            {en, te, ti, ri} <= 4'h0;
        else if (take && address[4:2] == 3'h0)
            en <= writedata[6];
        else if (take && address[4:2] == 3'h1)
            {ti, ri, te} <= {|writedata[7:6], |writedata[5:4], writedata[3]};

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_req;
        (read || write) && waitrequest;
    endsequence

    a_wait_once : assert property (s_req |=> !waitrequest)
        else $error("waitrequest held past one wait state");
    a_port_tx : assert property (
        !en |-> shared_transmit_pin_oe == port_dir_bit_zero
        && shared_transmit_pin_out == port_out_zero)
        else $error("transmit pin not under port control");
    a_port_rx : assert property (
        !en |-> shared_receive_pin_oe == port_dir_bit_one
        && shared_receive_pin_out == port_out_one)
        else $error("receive pin not under port control");
    a_rx_input : assert property (en |-> !shared_receive_pin_oe)
        else $error("receive pin driven while enabled");
    a_tx_drive : assert property (en && te |-> shared_transmit_pin_oe)
        else $error("transmit pin not driven");
    a_tx_release : assert property (
        en && $fell(te) |-> ##[0:400] !shared_transmit_pin_oe)
        else $error("transmit pin never released");
    a_tx_quiet : assert property (!en || !ti |-> !tx_irq)
        else $error("transmit irq without enable");
    a_rx_quiet : assert property (!ri |-> !rx_irq)
        else $error("receive irq without enable");
endmodule : spc_chk

bind spc_top spc_chk i_chk (.clk, .rst_n, .address, .read, .write,
    .writedata, .waitrequest, .port_dir_bit_zero, .port_dir_bit_one,
    .port_out_zero, .port_out_one, .shared_transmit_pin_out,
    .shared_transmit_pin_oe, .shared_receive_pin_out,
    .shared_receive_pin_oe, .tx_irq, .rx_irq);

// ===== verif/spc_remote.sv
/* remote line partner: sends and captures frames at 16 clocks a bit.
   assumes a baud divider of zero in the device. */
`timescale 1ns/10ps
module spc_remote
(
    input wire logic clk,
    input wire logic tx_line,
    output logic     rx_line
);
    logic noise;
    initial
    begin
        rx_line = 1'b1;
        noise = 1'b0;
    end
    // garbage on the line shows whether the pin is really cut off
    always @(posedge clk)
        if (noise)
            rx_line <= ~rx_line;

    task quiet;
        noise = 1'b0;
        @(posedge clk);
        rx_line <= 1'b1;
    endtask : quiet

    task send_char(input logic [7:0] c);
        logic [9:0] f;
        f = {1'b1, c, 1'b0};
        rx_line <= 1'b1;
        repeat (16) @(posedge clk);
        for (int i = 0; i < 10; i++)
        begin
            rx_line <= f[i];
            repeat (16) @(posedge clk);
        end
    endtask : send_char

    // returns {stop, char} and cycles waited for the start bit
    task recv_char(input int nb, output logic [9:0] c, output int w);
        w = 0;
        c = 10'h000;
        while (tx_line !== 1'b0)
        begin
            @(posedge clk);
            w++;
        end
        repeat (8) @(posedge clk);
        for (int i = 0; i <= nb; i++)
        begin
            repeat (16) @(posedge clk);
            c[(i == nb) ? 9 : i] = tx_line;
        end
    endtask : recv_char
endmodule : spc_remote

// ===== verif/tb.sv
/* self-checking bench for spc_top: registers, pins, frames, loop mode.
   assumes 16 clocks per bit with the baud divider at zero. */
`timescale 1ns/10ps
module tb;
    logic        clk, rst_n, read, write, waitrequest;
    logic [4:0]  address;
    logic [31:0] writedata, readdata, rd, rv;
    logic        port_dir_bit_zero, port_dir_bit_one;
    logic        port_out_zero, port_out_one, shared_receive_pin_in;
    logic        shared_transmit_pin_out, shared_transmit_pin_oe;
    logic        shared_receive_pin_out, shared_receive_pin_oe;
    logic        tx_irq, rx_irq;
    logic [9:0]  got;
    logic [7:0]  modes [4] = '{8'h40, 8'h50, 8'h42, 8'h53};
    int          errors, checks_done, cycles, seed, nb, e, w;
    int          exp_q[$];
    wire         tx_line = shared_transmit_pin_oe ? shared_transmit_pin_out
                                                  : 1'b1;

    spc_top i_spc_top (.clk, .rst_n, .address, .read, .write, .writedata,
        .readdata, .waitrequest, .port_dir_bit_zero, .port_dir_bit_one,
        .port_out_zero, .port_out_one, .shared_transmit_pin_out,
        .shared_transmit_pin_oe, .shared_receive_pin_in,
        .shared_receive_pin_out, .shared_receive_pin_oe, .tx_irq, .rx_irq);
    spc_remote i_spc_remote (.clk, .tx_line,
        .rx_line(shared_receive_pin_in));

    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            errors++;
            test_done();
        end
    end

    task test_done;
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : test_done

    task cmp_word(input logic [31:0] g, input logic [31:0] x);
        checks_done++;
        if (g !== x)
        begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, g, x);
        end
    endtask : cmp_word

    // one avalon transfer, held until waitrequest is seen low
    task bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        @(posedge clk);
        address <= a;
        writedata <= d;
        write <= wr;
        read <= !wr;
        @(posedge clk);
        while (waitrequest !== 1'b0)
            @(posedge clk);
        rd = readdata;
        write <= 1'b0;
        read <= 1'b0;
    endtask : bus

    initial
    begin
        seed = 32'hfad2;
        {rst_n, read, write, address, writedata} = '0;
        {port_dir_bit_zero, port_out_zero} = 2'b00;
        {port_dir_bit_one, port_out_one} = 2'b00;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        bus(0, 5'h00, 0); cmp_word(rd, 32'h0);
        bus(0, 5'h04, 0); cmp_word(rd, 32'h0);
        bus(0, 5'h08, 0); cmp_word(rd, 32'hc0);
        bus(1, 5'h1c, 32'hff);
        bus(0, 5'h1c, 0); cmp_word(rd, 32'h0);
        repeat (8)
        begin
            @(posedge clk);
            rv = $random(seed);
            {port_dir_bit_zero, port_out_zero} <= rv[3:2];
            {port_dir_bit_one, port_out_one} <= rv[1:0];
            @(negedge clk);
            cmp_word({shared_transmit_pin_oe, shared_transmit_pin_out,
                shared_receive_pin_oe, shared_receive_pin_out}, rv[3:0]);
        end
        $display("test reset and port control done");
        bus(1, 5'h10, 0);
        bus(1, 5'h00, 32'h40);
        @(negedge clk);
        cmp_word({shared_transmit_pin_oe, shared_receive_pin_oe}, 0);
        for (int m = 0; m < 4; m++)
        begin
            bus(1, 5'h00, {24'h0, modes[m]});
            if (m == 0)
                bus(1, 5'h04, 32'h08);
            rv = $random(seed);
            nb = modes[m][4] ? 9 : 8;
            e = rv & ((1 << nb) - 1);
            if (modes[m][1])
                e[nb - 1] = ^(e & ((1 << (nb - 1)) - 1)) ^ modes[m][0];
            exp_q.push_back(e | 32'h200);
            fork
                i_spc_remote.recv_char(nb, got, w);
                bus(1, 5'h0c, rv);
            join
            cmp_word(got, exp_q.pop_front());
            if (m == 0)
                cmp_word(w > 155 && w < 200, 1);
            repeat (16) @(posedge clk);
        end
        bus(1, 5'h14, 1);
        fork
            i_spc_remote.recv_char(9, got, w);
            bus(1, 5'h0c, 0);
        join
        cmp_word(got, 10'h3ff);
        bus(1, 5'h14, 0);
        $display("test frame formats done");
        bus(1, 5'h04, 32'h88);
        @(negedge clk);
        cmp_word(tx_irq, 1);
        bus(1, 5'h04, 0);
        @(negedge clk);
        cmp_word(shared_transmit_pin_oe, 0);
        bus(1, 5'h00, 32'hc0);
        bus(1, 5'h04, 32'h2c);
        i_spc_remote.noise = 1'b1;
        rv = $random(seed);
        bus(1, 5'h0c, rv);
        do
            bus(0, 5'h08, 0);
        while (rd[5] !== 1'b1);
        cmp_word(rx_irq, 1);
        bus(0, 5'h0c, 0); cmp_word(rd[7:0], rv[7:0]);
        @(negedge clk);
        cmp_word(rx_irq, 0);
        i_spc_remote.quiet();
        bus(1, 5'h00, 32'h40);
        $display("test loop mode done");
        rv = $random(seed);
        i_spc_remote.send_char(rv[7:0]);
        bus(1, 5'h04, 32'h88);
        bus(0, 5'h08, 0); cmp_word(rd[5], 1);
        bus(0, 5'h0c, 0); cmp_word(rd[7:0], rv[7:0]);
        bus(1, 5'h00, 0);
        bus(0, 5'h08, 0); cmp_word(rd[7:6], 2'b11);
        cmp_word(tx_irq, 0);
        $display("test receive and disable done");
        test_done();
    end
endmodule : tb
